// file: fcsm_host.sv
`timescale 1ns/1ps
// Behaviour
// - write only with enable and write strobe low, output enable high.
// - host writes reset after time-limit flag or in identification mode; fcsm_host does so only on an FCSM_OP_RESET request.
// - two unlocks plus identification command enter identification mode.
// - byte program is two unlocks, set-up command, then address with data.
module fcsm_host #(
  parameter logic [16:0] UNLOCK_ADDR1 = fcsm_pkg::UNLOCK_ADDR1,
  parameter logic [16:0] UNLOCK_ADDR2 = fcsm_pkg::UNLOCK_ADDR2,
  parameter logic [7:0]  UNLOCK_DATA1 = fcsm_pkg::UNLOCK_DATA1,
  parameter logic [7:0]  UNLOCK_DATA2 = fcsm_pkg::UNLOCK_DATA2,
  parameter logic [7:0]  CMD_RESET    = fcsm_pkg::CMD_RESET,
  parameter logic [7:0]  CMD_IDENT    = fcsm_pkg::CMD_IDENT,
  parameter logic [7:0]  CMD_PROG     = fcsm_pkg::CMD_PROG
) (
  // clocking
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // user request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [2:0]  req_op,
  input  wire logic [16:0] req_addr,
  input  wire logic [7:0]  req_data,
  // user answer
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             prog_done,
  output logic             prog_fail,
  // flash pins
  output logic [16:0]      flash_addr,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  input  wire logic [7:0]  flash_dq_i,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe_n
);
  typedef enum logic [2:0] {
    FCSM_IDLE  = 3'b000,
    FCSM_SETUP = 3'b001,
    FCSM_PULSE = 3'b011,
    FCSM_HOLD  = 3'b010,
    FCSM_RACC  = 3'b110,
    FCSM_POLL  = 3'b111,
    FCSM_GAP   = 3'b101
  } fcsm_state_t;

  fcsm_state_t state_r, state_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [1:0]  step_r, step_nxt;      // index within a multi-cycle sequence
  logic [1:0]  last_r, last_nxt;      // final step index of the sequence
  logic [2:0]  op_r, op_nxt;
  logic [16:0] addr_r, addr_nxt, tgt_addr_r, tgt_addr_nxt;
  logic [7:0]  data_r, data_nxt, tgt_data_r, tgt_data_nxt;
  logic        ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, dq_oe_n_r, dq_oe_n_nxt;
  logic        rsp_v_r, rsp_v_nxt, done_r, done_nxt, fail_r, fail_nxt;
  logic [7:0]  rsp_d_r, rsp_d_nxt, prev_poll_r, prev_poll_nxt;
  logic        first_poll_r, first_poll_nxt;
  logic [7:0]  dq_sync;

  fcsm_sync #(.W(8)) u_dq_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .din     (flash_dq_i),
    .dout    (dq_sync)
  );

  // address/data of each step of a command sequence
  function automatic logic [24:0] seq_word(input logic [2:0] op, input logic [1:0] step,
                                           input logic [16:0] ta, input logic [7:0] td);
    logic [24:0] w;
    w = {ta, td};
    if (op == fcsm_pkg::FCSM_OP_RESET) begin
      w = {ta, CMD_RESET};
    end else if (op == fcsm_pkg::FCSM_OP_IDENT || op == fcsm_pkg::FCSM_OP_PROG) begin
      unique case (step)
        2'd0: w = {UNLOCK_ADDR1, UNLOCK_DATA1};
        2'd1: w = {UNLOCK_ADDR2, UNLOCK_DATA2};
        2'd2: w = {UNLOCK_ADDR1, (op == fcsm_pkg::FCSM_OP_IDENT) ? CMD_IDENT : CMD_PROG};
        2'd3: w = {ta, td};
      endcase
    end
    return w;
  endfunction

  // sequencing of pin cycles
  always_comb begin
    logic [24:0] w;
    logic [7:0]  d;
    w             = '0;
    d             = dq_sync;
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    step_nxt      = step_r;
    last_nxt      = last_r;
    op_nxt        = op_r;
    addr_nxt      = addr_r;
    data_nxt      = data_r;
    tgt_addr_nxt  = tgt_addr_r;
    tgt_data_nxt  = tgt_data_r;
    ce_n_nxt      = ce_n_r;
    oe_n_nxt      = oe_n_r;
    we_n_nxt      = we_n_r;
    dq_oe_n_nxt   = dq_oe_n_r;
    rsp_v_nxt     = 1'b0;
    rsp_d_nxt     = rsp_d_r;
    done_nxt      = 1'b0;
    fail_nxt      = fail_r;
    prev_poll_nxt = prev_poll_r;
    first_poll_nxt = first_poll_r;
    unique case (state_r)
      FCSM_IDLE: begin
        if (req_valid) begin
          op_nxt       = req_op;
          tgt_addr_nxt = req_addr;
          tgt_data_nxt = req_data;
          step_nxt     = (req_op == fcsm_pkg::FCSM_OP_IDENT || req_op == fcsm_pkg::FCSM_OP_PROG) ? 2'd0 : 2'd3;
          last_nxt     = (req_op == fcsm_pkg::FCSM_OP_IDENT) ? 2'd2 : 2'd3;
          addr_nxt     = req_addr;
          fail_nxt     = 1'b0;
          cnt_nxt      = fcsm_pkg::SETUP_CYC;
          if (req_op == fcsm_pkg::FCSM_OP_READ) begin
            ce_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b0;                                // reads keep write strobe high
            state_nxt = FCSM_RACC;
            cnt_nxt   = fcsm_pkg::ACC_CYC;
          end else begin
            w         = seq_word(req_op, (req_op == fcsm_pkg::FCSM_OP_IDENT || req_op == fcsm_pkg::FCSM_OP_PROG)
                                 ? 2'd0 : 2'd3, req_addr, req_data);
            addr_nxt  = w[24:8];
            data_nxt  = w[7:0];
            state_nxt = FCSM_SETUP;
          end
        end
      end
      FCSM_SETUP: begin
        // address, data and output enable high settle before the strobes fall
        oe_n_nxt    = 1'b1;
        dq_oe_n_nxt = 1'b0;
        cnt_nxt     = cnt_r - 4'd1;
        if (cnt_r <= 4'd1) begin
          ce_n_nxt  = 1'b0;
          we_n_nxt  = 1'b0;
          cnt_nxt   = fcsm_pkg::PULSE_CYC;
          state_nxt = FCSM_PULSE;
        end
      end
      FCSM_PULSE: begin
        // strobe held far longer than the glitch filter
        cnt_nxt = cnt_r - 4'd1;
        if (cnt_r <= 4'd1) begin
          we_n_nxt  = 1'b1;                                  // data taken on this rise
          ce_n_nxt  = 1'b1;
          cnt_nxt   = fcsm_pkg::HIGH_CYC;
          state_nxt = FCSM_HOLD;
        end
      end
      FCSM_HOLD: begin
        cnt_nxt = cnt_r - 4'd1;
        if (cnt_r <= 4'd1) begin
          dq_oe_n_nxt = 1'b1;
          if (step_r != last_r) begin
            step_nxt  = step_r + 2'd1;
            w         = seq_word(op_r, step_r + 2'd1, tgt_addr_r, tgt_data_r);
            addr_nxt  = w[24:8];
            data_nxt  = w[7:0];
            cnt_nxt   = fcsm_pkg::SETUP_CYC;
            state_nxt = FCSM_SETUP;
          end else if (op_r == fcsm_pkg::FCSM_OP_PROG) begin
            // routine runs on its own; only status reads until it ends
            ce_n_nxt       = 1'b0;
            oe_n_nxt       = 1'b0;
            first_poll_nxt = 1'b1;
            cnt_nxt        = fcsm_pkg::ACC_CYC;
            state_nxt      = FCSM_POLL;
          end else begin
            done_nxt  = 1'b1;
            state_nxt = FCSM_IDLE;
          end
        end
      end
      FCSM_RACC: begin
        cnt_nxt = cnt_r - 4'd1;
        if (cnt_r <= 4'd1) begin
          rsp_v_nxt = 1'b1;                                  // array, id or status data
          rsp_d_nxt = d;
          ce_n_nxt  = 1'b1;
          oe_n_nxt  = 1'b1;
          cnt_nxt   = fcsm_pkg::HIGH_CYC;
          state_nxt = FCSM_GAP;
        end
      end
      FCSM_POLL: begin
        cnt_nxt = cnt_r - 4'd1;
        if (cnt_r <= 4'd1) begin
          ce_n_nxt       = 1'b1;
          oe_n_nxt       = 1'b1;
          prev_poll_nxt  = d;
          first_poll_nxt = 1'b0;
          cnt_nxt        = fcsm_pkg::HIGH_CYC;
          state_nxt      = FCSM_GAP;
          if (!first_poll_r && d[fcsm_pkg::TOGGLE_BIT] == prev_poll_r[fcsm_pkg::TOGGLE_BIT]) begin
            // toggle stopped: routine ended, device back in array read
            done_nxt = 1'b1;
            fail_nxt = (d != tgt_data_r);                    // protected sector: byte left unprogrammed; zero-to-one ends by the limit bit
            op_nxt   = fcsm_pkg::FCSM_OP_READ;
          end else if (!first_poll_r && d[fcsm_pkg::TLIM_BIT] && prev_poll_r[fcsm_pkg::TLIM_BIT]) begin
            // two status reads with the limit bit: array data with bit five set is no halt
            fail_nxt = 1'b1;
            done_nxt = 1'b1;
            op_nxt   = fcsm_pkg::FCSM_OP_READ;
          end
        end
      end
      FCSM_GAP: begin
        cnt_nxt = cnt_r - 4'd1;
        if (cnt_r <= 4'd1) begin
          if (op_r == fcsm_pkg::FCSM_OP_PROG) begin
            ce_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b0;
            cnt_nxt   = fcsm_pkg::ACC_CYC;
            state_nxt = FCSM_POLL;
          end else begin
            state_nxt = FCSM_IDLE;
          end
        end
      end
      default: state_nxt = FCSM_IDLE;
    endcase
  end

  // state registers; pins idle deselected so no power-up write occurs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r      <= FCSM_IDLE;
      cnt_r        <= 4'h0;
      step_r       <= 2'h0;
      last_r       <= 2'h0;
      op_r         <= 3'h0;
      addr_r       <= 17'h00000;
      data_r       <= 8'h00;
      tgt_addr_r   <= 17'h00000;
      tgt_data_r   <= 8'h00;
      ce_n_r       <= 1'b1;
      oe_n_r       <= 1'b1;
      we_n_r       <= 1'b1;
      dq_oe_n_r    <= 1'b1;
      rsp_v_r      <= 1'b0;
      rsp_d_r      <= 8'h00;
      done_r       <= 1'b0;
      fail_r       <= 1'b0;
      prev_poll_r  <= 8'h00;
      first_poll_r <= 1'b0;
    end else if (ce) begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      step_r       <= step_nxt;
      last_r       <= last_nxt;
      op_r         <= op_nxt;
      addr_r       <= addr_nxt;
      data_r       <= data_nxt;
      tgt_addr_r   <= tgt_addr_nxt;
      tgt_data_r   <= tgt_data_nxt;
      ce_n_r       <= ce_n_nxt;
      oe_n_r       <= oe_n_nxt;
      we_n_r       <= we_n_nxt;
      dq_oe_n_r    <= dq_oe_n_nxt;
      rsp_v_r      <= rsp_v_nxt;
      rsp_d_r      <= rsp_d_nxt;
      done_r       <= done_nxt;
      fail_r       <= fail_nxt;
      prev_poll_r  <= prev_poll_nxt;
      first_poll_r <= first_poll_nxt;
    end
  end

  // outputs
  assign req_ready     = (state_r == FCSM_IDLE);
  assign rsp_valid     = rsp_v_r;
  assign rsp_data      = rsp_d_r;
  assign prog_done     = done_r;
  assign prog_fail     = fail_r;
  assign flash_addr    = addr_r;
  assign flash_ce_n    = ce_n_r;
  assign flash_oe_n    = oe_n_r;
  assign flash_we_n    = we_n_r;
  assign flash_dq_o    = data_r;
  assign flash_dq_oe_n = dq_oe_n_r;
endmodule

// file: fcsm_pkg.sv
package fcsm_pkg;
  // bus widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // default command codes and unlock words
  localparam logic [16:0] UNLOCK_ADDR1 = 17'h00555;
  localparam logic [16:0] UNLOCK_ADDR2 = 17'h002aa;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [7:0]  CMD_IDENT    = 8'h90;
  localparam logic [7:0]  CMD_PROG     = 8'ha0;

  // status bit positions of a polled byte
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TLIM_BIT   = 5;

  // pin timing, in ns, and derived cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETUP_NS    = 20;  // address/data setup before strobe falls
  localparam int T_PULSE_NS    = 40;  // strobe low time, well above glitch filter
  localparam int T_HIGH_NS     = 30;  // strobe high time between cycles
  localparam int T_ACC_NS      = 60;  // read access time
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HIGH_CYC  = 4'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ACC_CYC   = 4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // host request kinds
  typedef enum logic [2:0] {
    FCSM_OP_READ  = 3'h0,
    FCSM_OP_WRITE = 3'h1,
    FCSM_OP_RESET = 3'h2,
    FCSM_OP_IDENT = 3'h3,
    FCSM_OP_PROG  = 3'h4
  } fcsm_op_t;
endpackage

// file: fcsm_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change is taken once stages two and three agree
module fcsm_sync #(
  parameter int W = 8
) (
  // clocking
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] q_nxt;

  // stage one feeds only stage two
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign dout = q_r;
endmodule

// file: fcsm_host_sva.sv
`timescale 1ns/1ps
module fcsm_host_sva (
  // clocking
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ce,
  // user side
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [2:0]  req_op,
  input wire logic        rsp_valid,
  input wire logic        prog_done,
  // flash pins
  input wire logic [16:0] flash_addr,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic [7:0]  flash_dq_o,
  input wire logic        flash_dq_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [2:0] op_q;
  logic [3:0] nwr;
  wire        take = req_valid && req_ready && ce;
  // strobes counted per request, judged when the request ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_q <= 3'h0;
      nwr  <= 4'h0;
    end else if (take) begin
      op_q <= req_op;
      nwr  <= 4'h0;
    end else if ($fell(flash_we_n)) begin
      nwr <= nwr + 4'h1;
    end
  end
  chk_write_gate: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("strobe outside a write cycle");
  chk_strobe_len: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
    else $error("strobe width wrong");
  chk_write_setup: assert property ($fell(flash_we_n) |-> !$past(flash_dq_oe_n) && $stable(flash_addr))
    else $error("no setup before strobe");
  chk_write_hold: assert property (!flash_we_n |=> !flash_dq_oe_n && $stable(flash_dq_o) && $stable(flash_addr))
    else $error("data not held over strobe rise");
  chk_read_lat: assert property (take && req_op == 3'h0 |-> ##7 rsp_valid)
    else $error("read answer late");
  chk_ident_len: assert property (prog_done && op_q == 3'h3 |-> nwr == 4'h3)
    else $error("ident not three writes");
  chk_prog_len: assert property (prog_done && op_q == 3'h4 |-> nwr == 4'h4)
    else $error("program not four writes");
  chk_reset_len: assert property (prog_done && op_q == 3'h2 |-> nwr == 4'h1)
    else $error("reset not one write");
  cov_read: cover property (rsp_valid);
  cov_ident: cover property (prog_done && op_q == 3'h3);
  cov_prog: cover property (prog_done && op_q == 3'h4);
endmodule
bind fcsm_host fcsm_host_sva u_sva (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req_valid(req_valid),
  .req_ready(req_ready), .req_op(req_op), .rsp_valid(rsp_valid), .prog_done(prog_done),
  .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_n(flash_dq_oe_n));

// file: fcsm_flash_model.sv
`timescale 1ns/1ps
module fcsm_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5a,  // arbitrary value
  parameter logic [7:0] PART_ID  = 8'hc3   // arbitrary value
) (
  // pins
  input  wire logic [16:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dout
);
  typedef enum logic [2:0] {FM_ARRAY, FM_UL1, FM_UL2, FM_IDENT, FM_PSET, FM_BUSY} fcsm_fm_st_t;
  fcsm_fm_st_t st = FM_ARRAY;
  logic [7:0]  mem [int];
  logic        prot [4] = '{default: 1'b0};
  logic        tlim = 1'b0;
  logic        tog = 1'b0;
  logic        armed = 1'b0;  // a write low at power-up never arms
  logic [16:0] la;
  logic [7:0]  tgt;
  realtime     t_on;
  int          busy_ns = 200;
  wire         wr_on = !ce_n && !we_n && oe_n;
  wire         rd_on = !ce_n && !oe_n && we_n;
  function automatic logic [7:0] arr(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // address taken as the later enable falls
  always @(posedge wr_on) begin
    la = addr;
    t_on = $realtime;
    armed = 1'b1;
  end
  // data taken as the first enable rises; short glitches dropped
  always @(negedge wr_on) begin
    if (armed && $realtime - t_on >= 5.0) cmd(la, din);
    armed = 1'b0;
  end
  task automatic cmd(input logic [16:0] a, input logic [7:0] d);
    logic [7:0] old;
    old = arr(a);
    if (st == FM_BUSY) begin
      if (tlim && d == fcsm_pkg::CMD_RESET) begin
        tlim = 1'b0;
        st = FM_ARRAY;
      end
    end else if (d == fcsm_pkg::CMD_RESET) begin
      st = FM_ARRAY;  // any half-written sequence aborts
    end else begin
      case (st)
        FM_ARRAY: st = (a == fcsm_pkg::UNLOCK_ADDR1 && d == fcsm_pkg::UNLOCK_DATA1) ? FM_UL1 : FM_ARRAY;
        FM_UL1: st = (a == fcsm_pkg::UNLOCK_ADDR2 && d == fcsm_pkg::UNLOCK_DATA2) ? FM_UL2 : FM_ARRAY;
        FM_UL2: st = (a != fcsm_pkg::UNLOCK_ADDR1) ? FM_ARRAY : (d == fcsm_pkg::CMD_IDENT) ? FM_IDENT :
                     (d == fcsm_pkg::CMD_PROG) ? FM_PSET : FM_ARRAY;
        FM_PSET: begin
          st = FM_BUSY;
          tgt = d;
          fork
            begin
              #(busy_ns);  // self-timed routine
              if (prot[a[16:15]]) st = FM_ARRAY;
              else if (|(d & ~old)) tlim = 1'b1;  // zero to one halts
              else begin
                mem[a] = old & d;
                st = FM_ARRAY;
              end
            end
          join_none
        end
        default: ;  // identification holds until reset
      endcase
    end
  endtask
  // toggle flips on each status read
  always @(negedge oe_n) if (st == FM_BUSY) tog = !tog;
  // released bus shows the inverse of its last value, never a held copy
  always @(rd_on, st, addr, tog, tlim) begin
    if (!rd_on) dout = ~dout;
    else if (st == FM_BUSY) dout = {~tgt[7], tog, tlim, 5'h00};
    else if (st == FM_IDENT) dout = (addr[1:0] == 2'h0) ? MAKER_ID : (addr[1:0] == 2'h1) ? PART_ID :
                                   {7'h00, prot[addr[16:15]]};
    else dout = arr(addr);  // no erase here, so no suspended sector shows status
  end
endmodule

// file: fcsm_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
  localparam logic [7:0] ID_M = 8'h5a;  // arbitrary value
  localparam logic [7:0] ID_P = 8'hc3;  // arbitrary value
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [2:0]  req_op = 3'h0;
  logic [16:0] req_addr = 17'h00000;
  logic [7:0]  req_data = 8'h00;
  logic        req_ready, rsp_valid, prog_done, prog_fail, fl_ce_n, fl_oe_n, fl_we_n, dq_oe_n;
  logic [7:0]  rsp_data, dq_o, fm_dout;
  logic [16:0] fl_addr, a;
  int          errors = 0;
  int          checks = 0;
  logic [7:0]  ref_mem [int];
  wire  [7:0]  dq_bus = dq_oe_n ? fm_dout : dq_o;  // host wins while it drives
  fcsm_host dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .prog_done(prog_done), .prog_fail(prog_fail), .flash_addr(fl_addr), .flash_ce_n(fl_ce_n),
    .flash_oe_n(fl_oe_n), .flash_we_n(fl_we_n), .flash_dq_i(dq_bus), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n));
  fcsm_flash_model #(.MAKER_ID(ID_M), .PART_ID(ID_P)) fm (.addr(fl_addr), .ce_n(fl_ce_n), .oe_n(fl_oe_n),
    .we_n(fl_we_n), .din(dq_bus), .dout(fm_dout));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [7:0] ref_rd(input logic [16:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : 8'hff;
  endfunction
  // one request, held until taken, then its answer awaited
  task automatic op(input logic [2:0] o, input logic [16:0] x, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_op = o;
    req_addr = x;
    req_data = d;
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
    while (((o == 3'h0) ? rsp_valid : prog_done) !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    // a lost answer is a mismatch of its own
    if (n >= 3000) begin
      errors++;
      $display("MISMATCH %0t answer timed out", $time);
    end
  endtask
  task automatic rd(input logic [16:0] x, input logic [7:0] e);
    op(3'h0, x, 8'h00);
    `CHK(rsp_data, e)
  endtask
  // program against the reference; a halted routine is cleared by reset
  task automatic prog(input logic [16:0] x, input logic [7:0] d, input logic pr);
    logic zo;
    zo = |(d & ~ref_rd(x));
    fm.busy_ns = 50 + $urandom_range(2000);  // prompt and slow routines alike
    op(3'h4, x, d);
    @(negedge clk_sys);
    `CHK(prog_fail, pr | zo)
    if (!(pr | zo)) ref_mem[x] = d;
    if (zo && !pr) op(3'h2, x, 8'h00);
    rd(x, ref_rd(x));
  endtask
  task automatic seq3(input logic [7:0] d2, input logic [7:0] c);
    op(3'h1, fcsm_pkg::UNLOCK_ADDR1, fcsm_pkg::UNLOCK_DATA1);
    op(3'h1, fcsm_pkg::UNLOCK_ADDR2, d2);
    op(3'h1, fcsm_pkg::UNLOCK_ADDR1, c);
  endtask
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(59));
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    a = 17'($urandom);
    rd(a, 8'hff);
    for (int i = 0; i < 6; i++) prog(17'($urandom), 8'($urandom) | 8'h01, 1'b0);
    prog(17'h01234, 8'h0f, 1'b0);
    prog(17'h01234, 8'hf0, 1'b0);  // zero to one, then reset
    fm.prot[1] = 1'b1;
    op(3'h3, 17'h00000, 8'h00);
    rd(17'h00000, ID_M);
    rd(17'h00001, ID_P);
    rd(17'h08002, 8'h01);
    rd(17'h10002, 8'h00);
    op(3'h1, 17'($urandom), 8'h55);
    rd(17'h00000, ID_M);  // stray write keeps identification
    op(3'h2, 17'($urandom), 8'h00);
    rd(a, ref_rd(a));
    prog(17'h0a000, 8'h3c, 1'b1);
    fm.prot[1] = 1'b0;
    prog(17'h0a000, 8'h3c, 1'b0);
    seq3(8'h77, fcsm_pkg::CMD_IDENT);
    rd(17'h00000, ref_rd(17'h00000));
    seq3(fcsm_pkg::UNLOCK_DATA2, fcsm_pkg::CMD_PROG);
    op(3'h2, 17'h00000, 8'h00);
    op(3'h1, 17'h04444, 8'h00);
    rd(17'h04444, ref_rd(17'h04444));
    give_verdict();
  end
  // cut a hang short
  initial begin
    #500us;
    errors++;
    give_verdict();
  end
endmodule
